// *** rtl/rsp_port.sv ***
// serial command slave with interrupt flags and pin routing
// assumes host is spi mode 0 master; serial pins are asynchronous to CLK_IN
`timescale 1ns/10ps
module rsp_port
  import rsp_pkg::*;
(
  input  wire logic        CLK_IN,        // 250 MHz clock
  input  wire logic        RST_IN,        // sync reset, high
  input  wire logic        SCK_IN,        // serial clock from host
  input  wire logic        SEL_N_IN,      // frame select, low active
  input  wire logic        MOSI_IN,       // serial data in
  output logic             MISO_OUT,      // serial data out
  output logic             MISO_OE_OUT,   // high while driving data out
  output logic             BUSY_OUT,      // command being applied
  input  wire logic [15:0] EVENT_IN,      // one-cycle event pulses
  input  wire logic        TX_MODE_IN,    // radio in transmit
  output logic             IRQ_LINE_A_OUT, // pin a
  output logic             IRQ_LINE_B_OUT, // pin b, or antenna switch
  output logic             IRQ_LINE_C_OUT, // pin c, or oscillator supply
  output logic [2:0]       OSC_LEVEL_OUT, // oscillator supply level
  output logic [23:0]      OSC_TIMEOUT_OUT // oscillator start timeout
);
  ////////////////////////////////////////////////////////////////////////////
  logic sck_s, sel_n_s, mosi_s;
  logic sel_act_s;
  rsp_sync u_sck  (.clk_in(CLK_IN), .rst_in(RST_IN), .d_in(SCK_IN),   .q_out(sck_s));
  // select synchronised active high so reset leaves the port deselected, no false frame
  rsp_sync u_sel  (.clk_in(CLK_IN), .rst_in(RST_IN), .d_in(~SEL_N_IN), .q_out(sel_act_s));
  assign sel_n_s = ~sel_act_s;
  rsp_sync u_mosi (.clk_in(CLK_IN), .rst_in(RST_IN), .d_in(MOSI_IN),  .q_out(mosi_s));

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_APPLY = 3'b100
  } rsp_state_t;

  logic sck_p_q, sel_p_q;
  logic rise, fall, sel_fall, sel_rise;
  // 4 ns sampling of a 62.5 ns clock gives ample margin for edge finding
  assign rise     = sck_s & ~sck_p_q;           // RQ1
  assign fall     = ~sck_s & sck_p_q;
  assign sel_fall = ~sel_n_s & sel_p_q;         // RQ2
  assign sel_rise = sel_n_s & ~sel_p_q;

  rsp_state_t  st_q, st_d;
  logic [2:0]  bit_q, bit_d;
  logic [3:0]  byte_q, byte_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  op_q, op_d;
  logic [7:0]  tx_q, tx_d;
  logic [63:0] par_q, par_d;
  logic [15:0] glob_q, glob_d, ma_q, ma_d, mb_q, mb_d, mc_q, mc_d;
  logic [15:0] flag_q, flag_d;
  logic        ant_q, ant_d, oscen_q, oscen_d;
  logic [2:0]  lvl_q, lvl_d;
  logic [23:0] tmo_q, tmo_d;
  logic        miso_q, miso_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    byte_d = byte_q;
    sh_d = sh_q;
    op_d = op_q;
    tx_d = tx_q;
    par_d = par_q;
    glob_d = glob_q;
    ma_d = ma_q;
    mb_d = mb_q;
    mc_d = mc_q;
    ant_d = ant_q;
    oscen_d = oscen_q;
    lvl_d = lvl_q;
    tmo_d = tmo_q;
    miso_d = miso_q;
    flag_d = flag_q | EVENT_IN;
    case (st_q)
      ST_IDLE: begin
        if (sel_fall) begin                           // RQ2
          st_d = ST_SHIFT;
          bit_d = 3'h0;
          byte_d = 4'h0;
          tx_d = 8'h00;
          miso_d = 1'b0;
        end
      end
      ST_SHIFT: begin
        if (sel_rise) begin
          st_d = ST_APPLY;
        end else if (rise) begin                      // RQ12
          sh_d = {sh_q[6:0], mosi_s};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            byte_d = (byte_q == 4'hF) ? byte_q : byte_q + 4'h1;
            if (byte_q == 4'h0) begin
              op_d = {sh_q[6:0], mosi_s};
            end else if (byte_q < LEN_SET_ROUTING) begin
              par_d = {par_q[55:0], sh_q[6:0], mosi_s};
            end
            // read reply: status byte, then flags high, then flags low
            if (op_d == OP_READ_FLAGS && byte_q == 4'h0) begin // RQ7
              tx_d = flag_q[15:8];
            end else if (op_q == OP_READ_FLAGS && byte_q == 4'h1) begin
              tx_d = flag_q[7:0];
            end else begin
              tx_d = 8'h00;
            end
          end else begin
            tx_d = {tx_q[6:0], 1'b0};
          end
        end else if (fall) begin
          miso_d = tx_q[7];
        end
      end
      ST_APPLY: begin
        st_d = ST_IDLE;
        if (op_q == OP_SET_ROUTING && byte_q == LEN_SET_ROUTING) begin // RQ6
          glob_d = par_q[63:48];
          ma_d = par_q[47:32];
          mb_d = par_q[31:16];
          mc_d = par_q[15:0];
        end
        if (op_q == OP_CLEAR_FLAGS && byte_q == LEN_CLEAR_FLAGS) begin // RQ8
          flag_d = (flag_q & ~par_q[15:0]) | EVENT_IN;
        end
        if (op_q == OP_ANTENNA_SW && byte_q == LEN_ANTENNA_SW) begin   // RQ9
          ant_d = par_q[0];
        end
        if (op_q == OP_OSC_SUPPLY && byte_q == LEN_OSC_SUPPLY) begin   // RQ10
          oscen_d = 1'b1;
          lvl_d = par_q[26:24];
          tmo_d = par_q[23:0];
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_q <= ST_IDLE;
      sck_p_q <= 1'b0;
      sel_p_q <= 1'b1;
      bit_q <= 3'h0;
      byte_q <= 4'h0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      tx_q <= 8'h00;
      par_q <= 64'h0;
      glob_q <= MASK_RESET;
      ma_q <= MASK_RESET;
      mb_q <= MASK_RESET;
      mc_q <= MASK_RESET;
      flag_q <= 16'h0000;
      ant_q <= 1'b0;
      oscen_q <= 1'b0;
      lvl_q <= OSC_LEVEL_RESET;
      tmo_q <= OSC_TIMEOUT_RESET;
      miso_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sck_p_q <= sck_s;
      sel_p_q <= sel_n_s;
      bit_q <= bit_d;
      byte_q <= byte_d;
      sh_q <= sh_d;
      op_q <= op_d;
      tx_q <= tx_d;
      par_q <= par_d;
      glob_q <= glob_d;
      ma_q <= ma_d;
      mb_q <= mb_d;
      mc_q <= mc_d;
      flag_q <= flag_d;
      ant_q <= ant_d;
      oscen_q <= oscen_d;
      lvl_q <= lvl_d;
      tmo_q <= tmo_d;
      miso_q <= miso_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] live;
  logic        pin_a_q, pin_b_q, pin_c_q;
  logic        pin_a_d, pin_b_d, pin_c_d;
  assign live = flag_q & glob_q;
  always_comb begin
    pin_a_d = |(live & ma_q);                                      // RQ13 RQ5
    pin_b_d = ant_q ? TX_MODE_IN : |(live & mb_q);                 // RQ11
    pin_c_d = oscen_q ? 1'b1 : |(live & mc_q);                     // RQ10
  end
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      pin_c_q <= 1'b0;
    end else begin
      pin_a_q <= pin_a_d;
      pin_b_q <= pin_b_d;
      pin_c_q <= pin_c_d;
    end
  end

  assign IRQ_LINE_A_OUT = pin_a_q;
  assign IRQ_LINE_B_OUT = pin_b_q;
  assign IRQ_LINE_C_OUT = pin_c_q;
  assign MISO_OUT       = miso_q;
  assign MISO_OE_OUT    = ~sel_n_s;                                // RQ3
  assign BUSY_OUT       = (st_q == ST_APPLY);                      // RQ5
  assign OSC_LEVEL_OUT  = lvl_q;
  assign OSC_TIMEOUT_OUT = tmo_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_miso_idle;
    @(posedge CLK_IN) disable iff (RST_IN) $past(SEL_N_IN, 2) |-> !MISO_OE_OUT;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("data out driven while deselected"); // RQ3

  property p_frame_start;
    @(posedge CLK_IN) disable iff (RST_IN) (st_q == ST_IDLE && sel_fall) |=> st_q == ST_SHIFT;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame did not start"); // RQ2

  property p_routing;
    @(posedge CLK_IN) disable iff (RST_IN)
      (st_q == ST_APPLY && op_q == OP_SET_ROUTING && byte_q == LEN_SET_ROUTING)
      |=> glob_q == $past(par_q[63:48]) && mc_q == $past(par_q[15:0]);
  endproperty
  a_routing: assert property (p_routing) else $error("masks not loaded"); // RQ6

  property p_clear;
    @(posedge CLK_IN) disable iff (RST_IN)
      (st_q == ST_APPLY && op_q == OP_CLEAR_FLAGS && byte_q == LEN_CLEAR_FLAGS && EVENT_IN == 16'h0)
      |=> (flag_q & $past(par_q[15:0])) == 16'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared"); // RQ8

  property p_antenna;
    @(posedge CLK_IN) disable iff (RST_IN) ant_q |=> IRQ_LINE_B_OUT == $past(TX_MODE_IN);
  endproperty
  a_antenna: assert property (p_antenna) else $error("antenna switch level wrong"); // RQ11

  property p_pin_a;
    @(posedge CLK_IN) disable iff (RST_IN) |(flag_q & glob_q & ma_q) |=> IRQ_LINE_A_OUT;
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a not asserted"); // RQ13

  property p_osc;
    @(posedge CLK_IN) disable iff (RST_IN) oscen_q |=> IRQ_LINE_C_OUT;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator supply not driven"); // RQ10

  property p_event_sticks;
    @(posedge CLK_IN) disable iff (RST_IN) EVENT_IN[0] |=> flag_q[0];
  endproperty
  a_event_sticks: assert property (p_event_sticks) else $error("event lost"); // RQ7
endmodule // rsp_port

// *** include/rsp_pkg.sv ***
// package for the radio serial command and interrupt port
// assumes a 250 MHz system clock and a serial clock sampled as a plain input
//
// Summary of operation
// [RQ1] device is slave only; shifts on the host's serial clock up to 16 MHz
// [RQ2] select falling edge starts a new command frame
// [RQ3] data output is undriven while select is high
// [RQ4] host waits 100 us after wake-up select edge before first clock edge
// [RQ5] busy line is used and at least one pin carries interrupts
// [RQ6] opcode 08 loads enable mask then routing masks for pins a, b, c
// [RQ7] opcode 12 returns the current interrupt flags
// [RQ8] opcode 02 clears flags given by a 16-bit mask; cleared flags release pins
// [RQ9] opcode 9D with enable turns pin b into antenna switch control
// [RQ10] opcode 97 takes supply level and 24-bit timeout; pin c drives oscillator supply
// [RQ11] antenna switch pin is 1 in transmit, 0 in receive
// [RQ12] host sends opcode then parameters msb first in one frame, after busy low
// [RQ13] each pin asserts while any enabled and routed flag is set; pins b and c follow antenna switch and osc supply when enabled
package rsp_pkg;
  localparam logic [7:0] OP_SET_ROUTING   = 8'h08;
  localparam logic [7:0] OP_READ_FLAGS    = 8'h12;
  localparam logic [7:0] OP_CLEAR_FLAGS   = 8'h02;
  localparam logic [7:0] OP_ANTENNA_SW    = 8'h9D;
  localparam logic [7:0] OP_OSC_SUPPLY    = 8'h97;
  localparam logic [15:0] MASK_RESET      = 16'h0000;
  localparam logic [2:0] OSC_LEVEL_RESET  = 3'h0;
  localparam logic [23:0] OSC_TIMEOUT_RESET = 24'h000000;
  // byte counts of each command, opcode included
  localparam logic [3:0] LEN_SET_ROUTING  = 4'h9;
  localparam logic [3:0] LEN_READ_FLAGS   = 4'h3;
  localparam logic [3:0] LEN_CLEAR_FLAGS  = 4'h3;
  localparam logic [3:0] LEN_ANTENNA_SW   = 4'h2;
  localparam logic [3:0] LEN_OSC_SUPPLY   = 4'h5;
  localparam int WAKE_SETUP_US = 100;
  localparam int CLK_MHZ = 250;
  localparam int WAKE_SETUP_CYC = WAKE_SETUP_US * CLK_MHZ;
endpackage

// *** rtl/rsp_sync.sv ***
// two-flop synchroniser for one level input
// assumes clk is the system clock; no reset on the data path needed beyond zero
`timescale 1ns/10ps
module rsp_sync (
  input  wire logic clk_in,   // system clock
  input  wire logic rst_in,   // synchronous reset
  input  wire logic d_in,     // asynchronous level
  output logic      q_out     // synchronised level
);
  logic meta_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule // rsp_sync

// *** verif/rsp_host.sv ***
// host model: serial bus master for the radio command port
// assumes the system clock is given only to time the serial edges
`timescale 1ns/10ps
module rsp_host
  import rsp_pkg::*;
(
  input  wire logic clk_in,    // system clock
  input  wire logic busy_in,   // device busy
  input  wire logic miso_in,   // serial data from device
  input  wire logic oe_in,     // device drives miso
  output logic      sck_out,   // serial clock
  output logic      sel_n_out, // frame select, low active
  output logic      mosi_out   // serial data to device
);
  logic awake = 1'b0;
  logic saw_busy = 1'b0;
  initial begin
    sck_out = 1'b0;
    sel_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // half serial period of 80 ns
  task automatic half();
    repeat (20) @(negedge clk_in);
  endtask
  // n bits msb first; an undriven miso reads as unknown
  task automatic xfer(input logic [71:0] tx, input int n, output logic [71:0] rx);
    rx = '0;
    while (busy_in === 1'b1) @(negedge clk_in);
    sel_n_out = 1'b0;
    if (!awake) begin
      repeat (WAKE_SETUP_CYC) @(negedge clk_in);
      awake = 1'b1;
    end
    half();
    for (int i = n - 1; i >= 0; i--) begin
      mosi_out = tx[i];
      half();
      rx = {rx[70:0], (oe_in === 1'b1) ? miso_in : 1'bx};
      sck_out = 1'b1;
      half();
      sck_out = 1'b0;
    end
    half();
    sel_n_out = 1'b1;
    // released line shows no stale value
    mosi_out = ~mosi_out;
    saw_busy = 1'b0;
    repeat (40) @(negedge clk_in) if (busy_in === 1'b1) saw_busy = 1'b1;
  endtask
endmodule // rsp_host

// *** verif/test_radio_spi_command_irq_port.sv ***
// testbench for the radio serial command and interrupt port
// assumes the host model drives the serial clock, select and data-in pins; the device drives miso
`timescale 1ns/10ps
module test_radio_spi_command_irq_port;
  import rsp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] ev = 16'h0000;
  logic        tx_mode = 1'b0;
  logic [71:0] rx;
  wire         sck, sel_n, mosi, miso, miso_oe, busy, irq_a, irq_b, irq_c;
  wire [2:0]   osc_lvl;
  wire [23:0]  osc_to;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #2 clk = ~clk;
  rsp_port uut (.CLK_IN(clk), .RST_IN(rst), .SCK_IN(sck), .SEL_N_IN(sel_n),
    .MOSI_IN(mosi), .MISO_OUT(miso), .MISO_OE_OUT(miso_oe), .BUSY_OUT(busy),
    .EVENT_IN(ev), .TX_MODE_IN(tx_mode), .IRQ_LINE_A_OUT(irq_a),
    .IRQ_LINE_B_OUT(irq_b), .IRQ_LINE_C_OUT(irq_c), .OSC_LEVEL_OUT(osc_lvl),
    .OSC_TIMEOUT_OUT(osc_to));
  rsp_host host (.clk_in(clk), .busy_in(busy), .miso_in(miso), .oe_in(miso_oe),
    .sck_out(sck), .sel_n_out(sel_n), .mosi_out(mosi));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic pulse(input logic [15:0] bits);
    @(negedge clk) ev = bits;
    @(negedge clk) ev = 16'h0000;
    repeat (4) @(negedge clk);
  endtask
  // ceiling: about twice the wake wait plus the eight frames
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      failures++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk);
    check(24'(miso_oe), 24'h000000);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(24'(miso_oe), 24'h000000);
    host.xfer({OP_SET_ROUTING, 64'h0005_0001_0004_0006}, 72, rx);
    check(24'(host.saw_busy), 24'h000001);
    pulse(16'h0001);
    check(24'({irq_a, irq_b, irq_c}), 24'h000004);
    // bit 1 is not enabled, so it never reaches a pin
    pulse(16'h0006);
    check(24'({irq_a, irq_b, irq_c}), 24'h000007);
    host.xfer(72'({OP_READ_FLAGS, 16'h0000}), 24, rx);
    check(rx[23:0], 24'h000007);
    host.xfer(72'({OP_CLEAR_FLAGS, 16'h0001}), 24, rx);
    check(24'({irq_a, irq_b, irq_c}), 24'h000003);
    // short clear frame must be ignored
    host.xfer(72'({OP_CLEAR_FLAGS, 8'hFF}), 16, rx);
    host.xfer(72'({OP_READ_FLAGS, 16'h0000}), 24, rx);
    check(rx[23:0], 24'h000006);
    host.xfer(72'({OP_ANTENNA_SW, 8'h01}), 16, rx);
    check(24'(irq_b), 24'h000000);
    @(negedge clk) tx_mode = 1'b1;
    repeat (4) @(negedge clk);
    check(24'(irq_b), 24'h000001);
    host.xfer(72'({OP_CLEAR_FLAGS, 16'hFFFF}), 24, rx);
    check(24'({irq_a, irq_c}), 24'h000000);
    host.xfer(72'({OP_OSC_SUPPLY, 8'h05, 24'h123456}), 40, rx);
    check(24'(irq_c), 24'h000001);
    check(24'(osc_lvl), 24'h000005);
    check(osc_to, 24'h123456);
    check(24'(miso_oe), 24'h000000);
    end_sim();
  end
endmodule // test_radio_spi_command_irq_port
